// >>> shared/area_wait_pkg.sv
// Purpose: Constants and types for the area 5B wait control and access engine.
// Assumes: Avalon-MM word addressing, 32-bit register data.
// Notes: Lower wait-control bits below bit 7 are not implemented and read as zero.
package area_wait_pkg;
    // Register word indices (byte address is four times the index)
    localparam logic [2:0] REG_WAIT_CTRL = 3'h0;
    localparam logic [2:0] REG_AREA_MODE = 3'h1;
    localparam logic [2:0] REG_EXT_ADDR = 3'h2;
    localparam logic [2:0] REG_EXT_DATA = 3'h3;
    localparam logic [2:0] REG_COMMAND = 3'h4;

    // Wait control field positions
    localparam int MUX_WAIT_POS = 20;
    localparam int WRITE_WAIT_LSB = 16;
    localparam int SETUP_LSB = 11;
    localparam int READ_WAIT_LSB = 7;
    localparam logic [31:0] WAIT_CTRL_MASK = 32'h0017_1f80;

    // Values after reset
    localparam logic [3:0] READ_WAIT_RESET = 4'ha;
    localparam logic [2:0] WRITE_WAIT_RESET = 3'h0;
    localparam logic [1:0] SETUP_RESET = 2'h0;
    localparam logic MUX_WAIT_RESET = 1'b0;

    // Area mode and command bits
    localparam int MODE_MUX_POS = 0;
    localparam int MODE_EXT_WAIT_POS = 1;
    localparam int CMD_READ_POS = 0;
    localparam int CMD_WRITE_POS = 1;
    localparam int STAT_BUSY_POS = 0;

    // Cycle counts
    localparam logic [4:0] PROHIBITED_WAIT = 5'h18;
    localparam logic [4:0] MUX_ADDR_WAIT_CYCLES = 5'h01;

    typedef struct packed {
        logic mux_addr_wait;
        logic [2:0] write_wait;
        logic [1:0] strobe_setup;
        logic [3:0] read_wait;
    } wait_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AWAIT = 3'b011,
        ST_SETUP = 3'b010,
        ST_STROBE = 3'b110,
        ST_HOLD = 3'b111
    } access_state_t;
endpackage

// >>> design/pin_sync3.sv
// Purpose: Three-stage input synchroniser with agreement filter, one lane per bit.
// Assumes: Inputs are asynchronous pins.
// Notes: A change is accepted once stages two and three agree.
`timescale 1ns/10ps
module pin_sync3 #(
    parameter int WIDTH = 1
) (
    input wire logic mclk, // System clock
    input wire logic resetn, // Async reset, active low
    input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
    input wire logic [WIDTH-1:0] reset_level, // Level shown after reset
    output logic [WIDTH-1:0] level_out // Filtered level
);
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_lane
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic seen_q;
            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    s1_q <= 1'b1;
                    s2_q <= 1'b1;
                    s3_q <= 1'b1;
                    seen_q <= 1'b0;
                end else begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    seen_q <= 1'b1;
                end
            end
            logic out_q;
            // Reset level is caught by a clocked process, not the async branch
            always_ff @(posedge mclk) begin
                if (!seen_q) begin
                    out_q <= reset_level[i];
                end else if (s2_q == s3_q) begin
                    out_q <= s3_q;
                end
            end
            assign level_out[i] = out_q;
        end
    endgenerate
endmodule // pin_sync3

// >>> design/area_bus_wait_control.sv
// Purpose: Area 5B wait control register and external access engine on Avalon-MM.
// Assumes: mclk at 10 MHz; external device answers within the programmed waits.
// Notes: Strobes come from falling-edge flops to give half-cycle setup.
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
module area_bus_wait_control
    import area_wait_pkg::*;
#(
    parameter int AW = 16,
    parameter int DW = 16
) (
    input wire logic mclk, // System clock
    input wire logic resetn, // Async reset, active low
    input wire logic [2:0] avs_address, // Word index
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall, high until answer
    output logic [AW-1:0] ext_addr, // External address
    output logic area_select_n, // Area chip select, low active
    output logic ext_ale, // Address latch enable (mux mode)
    output logic ext_rd_n, // Read strobe, low active
    output logic ext_we_n, // Write strobe, low active
    output logic [DW-1:0] ext_data_out, // Data/address bus out
    output logic ext_data_oe, // Data bus output enable
    input wire logic [DW-1:0] ext_data_in, // Data bus in
    input wire logic ext_wait_n // External wait pin, low active
);
    // Refuse widths the register word and the data path cannot carry
    if (AW < 1 || AW > 32 || DW < AW || DW > 32) begin : g_bad_width
        $error("area_bus_wait_control: unsupported AW/DW");
    end

    wait_ctrl_t wcr_q;
    logic mux_mode_q, ext_wait_en_q;
    logic [AW-1:0] addr_reg_q;
    logic [DW-1:0] wdata_q, rdata_q;
    logic is_write_q;
    access_state_t state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    logic wait_q;

    // Bus slave: one wait cycle, answer on the second edge
    wire req = avs_read | avs_write;
    wire accept = req & wait_q;
    wire do_write = avs_write & wait_q;
    wire busy = (state_q != ST_IDLE);
    wire sel_wcr = (avs_address == REG_WAIT_CTRL);
    wire sel_mode = (avs_address == REG_AREA_MODE);
    wire sel_addr = (avs_address == REG_EXT_ADDR);
    wire sel_data = (avs_address == REG_EXT_DATA);
    wire sel_cmd = (avs_address == REG_COMMAND);
    wire start_rd = do_write & sel_cmd & avs_writedata[CMD_READ_POS] & ~busy;
    wire start_wr = do_write & sel_cmd & avs_writedata[CMD_WRITE_POS] & ~busy
                    & ~avs_writedata[CMD_READ_POS];
    wire start = start_rd | start_wr;

    wire [31:0] wcr_word = ({11'h000, wcr_q.mux_addr_wait, 1'b0, wcr_q.write_wait, 3'h0,
                             wcr_q.strobe_setup, wcr_q.read_wait, 7'h00})
                           & WAIT_CTRL_MASK;
    wire [31:0] rd_mux = sel_wcr ? wcr_word :
                         sel_mode ? {30'h0, ext_wait_en_q, mux_mode_q} :
                         sel_addr ? {{(32-AW){1'b0}}, addr_reg_q} :
                         sel_data ? {{(32-DW){1'b0}}, rdata_q} :
                         sel_cmd ? {31'h0, busy} : 32'h0;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wait_q <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            wait_q <= ~accept;
            if (avs_read & wait_q) begin
                avs_readdata <= rd_mux;
            end
        end
    end
    assign avs_waitrequest = wait_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wcr_q <= '{MUX_WAIT_RESET, WRITE_WAIT_RESET, SETUP_RESET, READ_WAIT_RESET};
            mux_mode_q <= 1'b0;
            ext_wait_en_q <= 1'b0;
            addr_reg_q <= '0;
            wdata_q <= '0;
        end else if (do_write) begin
            if (sel_wcr) begin
                wcr_q.mux_addr_wait <= avs_writedata[MUX_WAIT_POS];
                wcr_q.write_wait <= avs_writedata[WRITE_WAIT_LSB +: 3];
                wcr_q.strobe_setup <= avs_writedata[SETUP_LSB +: 2];
                wcr_q.read_wait <= avs_writedata[READ_WAIT_LSB +: 4];
            end
            if (sel_mode) begin
                mux_mode_q <= avs_writedata[MODE_MUX_POS];
                ext_wait_en_q <= avs_writedata[MODE_EXT_WAIT_POS];
            end
            if (sel_addr) begin
                addr_reg_q <= avs_writedata[AW-1:0];
            end
            if (sel_data) begin
                wdata_q <= avs_writedata[DW-1:0];
            end
        end
    end

    // Wait count lookup; prohibited codes fall back to the longest wait
    logic [4:0] read_waits;
    always_comb begin
        case (wcr_q.read_wait)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: read_waits = {1'b0, wcr_q.read_wait};
            4'h7: read_waits = 5'h08;
            4'h8: read_waits = 5'h0a;
            4'h9: read_waits = 5'h0c;
            4'ha: read_waits = 5'h0e;
            4'hb: read_waits = 5'h12;
            4'hc: read_waits = 5'h18;
            default: read_waits = PROHIBITED_WAIT;
        endcase
    end
    wire [4:0] write_waits = (wcr_q.write_wait == 3'h0) ? read_waits :
                             {2'b00, wcr_q.write_wait - 3'h1};
    wire [4:0] access_waits = is_write_q ? write_waits : read_waits;

    logic ext_wait_lvl;
    pin_sync3 #(.WIDTH(1)) u_wait_sync (
        .mclk(mclk),
        .resetn(resetn),
        .pin_in(ext_wait_n),
        .reset_level(1'b1),
        .level_out(ext_wait_lvl)
    );
    wire ext_hold = ext_wait_en_q & ~ext_wait_lvl;

    // Setup entry: code 0 goes straight to the strobe phase
    wire setup_zero = (wcr_q.strobe_setup == 2'h0);
    wire [4:0] setup_cnt = {3'h0, wcr_q.strobe_setup - 2'h1};
    wire [4:0] strobe_cnt = is_write_q ? write_waits : read_waits;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = mux_mode_q ? ST_ADDR : (setup_zero ? ST_STROBE : ST_SETUP);
                    cnt_d = setup_zero ? (start_wr ? write_waits : read_waits) : setup_cnt;
                end
            end
            ST_ADDR: begin
                if (wcr_q.mux_addr_wait) begin
                    state_d = ST_AWAIT;
                    cnt_d = MUX_ADDR_WAIT_CYCLES - 5'h01;
                end else begin
                    state_d = setup_zero ? ST_STROBE : ST_SETUP;
                    cnt_d = setup_zero ? strobe_cnt : setup_cnt;
                end
            end
            ST_AWAIT: begin
                if (cnt_q == 5'h0) begin
                    state_d = setup_zero ? ST_STROBE : ST_SETUP;
                    cnt_d = setup_zero ? strobe_cnt : setup_cnt;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            ST_SETUP: begin
                if (cnt_q == 5'h0) begin
                    state_d = ST_STROBE;
                    cnt_d = access_waits;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            ST_STROBE: begin
                if (cnt_q != 5'h0) begin
                    cnt_d = cnt_q - 5'h01;
                end else if (!ext_hold) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    wire is_write_next = start ? start_wr : is_write_q;
    wire cs_d = (state_d != ST_IDLE);
    wire ale_d = (state_d == ST_ADDR);
    wire oe_d = ale_d | (cs_d & is_write_next);
    wire capture = (state_q == ST_STROBE) & (state_d == ST_HOLD) & ~is_write_q;
    // Address is zero-extended onto the shared bus during the latch cycle
    wire [DW-1:0] bus_d = ale_d ? DW'(addr_reg_q) : wdata_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h0;
            is_write_q <= 1'b0;
            area_select_n <= 1'b1;
            ext_ale <= 1'b0;
            ext_data_oe <= 1'b0;
            ext_data_out <= '0;
            ext_addr <= '0;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            is_write_q <= is_write_next;
            area_select_n <= ~cs_d;
            ext_ale <= ale_d;
            ext_data_oe <= oe_d;
            ext_data_out <= bus_d;
            ext_addr <= start ? addr_reg_q : ext_addr;
            if (capture) begin
                rdata_q <= ext_data_in;
            end
        end
    end

    // Strobes follow the strobe state half a cycle late, off the falling edge
    always_ff @(negedge mclk or negedge resetn) begin
        if (!resetn) begin
            ext_rd_n <= 1'b1;
            ext_we_n <= 1'b1;
        end else begin
            ext_rd_n <= ~((state_q == ST_STROBE) & ~is_write_q);
            ext_we_n <= ~((state_q == ST_STROBE) & is_write_q);
        end
    end
endmodule // area_bus_wait_control

// >>> sim/area_bus_wait_control_chk.sv
// Purpose: Port checks for the area wait control block.
// Assumes: Bound to every instance of the design.
// Notes: Strobe checks sample on both clock edges.
`timescale 1ns/10ps
module area_bus_wait_control_chk
    import area_wait_pkg::*;
#(
    parameter int AW = 16,
    parameter int DW = 16
) (
    input wire logic mclk, // Clock
    input wire logic resetn, // Reset
    input wire logic [2:0] avs_address, // Index
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [31:0] avs_writedata, // Wdata
    input wire logic [31:0] avs_readdata, // Rdata
    input wire logic avs_waitrequest, // Stall
    input wire logic [AW-1:0] ext_addr, // Address
    input wire logic area_select_n, // Select
    input wire logic ext_ale, // Latch
    input wire logic ext_rd_n, // Read strobe
    input wire logic ext_we_n, // Write strobe
    input wire logic [DW-1:0] ext_data_out, // Data out
    input wire logic ext_data_oe, // Enable
    input wire logic [DW-1:0] ext_data_in, // Data in
    input wire logic ext_wait_n // Wait pin
);
    // Strobes as they stood before each rising edge
    logic [1:0] rise_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) rise_q <= 2'h3;
        else rise_q <= {ext_rd_n, ext_we_n};
    end
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    a_resv_zero: assert property (
        avs_read && !avs_waitrequest && avs_address == REG_WAIT_CTRL
        |-> (avs_readdata & ~WAIT_CTRL_MASK) == 32'h0) else $error("reserved bits set");
    a_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("late");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer too long");
    a_strobe_edge: assert property (@(negedge mclk) disable iff (!resetn)
        {ext_rd_n, ext_we_n} == rise_q) else $error("strobe moved on rising edge");
    a_strobe_in_sel: assert property (
        !ext_rd_n || !ext_we_n |-> !area_select_n) else $error("strobe outside select");
    a_setup_first: assert property (@(negedge mclk) disable iff (!resetn)
        $fell(area_select_n) |-> ext_rd_n && ext_we_n) else $error("strobe with select");
    a_one_strobe: assert property (ext_rd_n || ext_we_n) else $error("both strobes low");
    a_oe_drive: assert property ((ext_ale || !ext_we_n) |-> ext_data_oe)
        else $error("data bus not driven");
    a_ale_single: assert property (ext_ale |=> !ext_ale && ext_rd_n && ext_we_n)
        else $error("latch pulse wrong");
endmodule // area_bus_wait_control_chk
bind area_bus_wait_control area_bus_wait_control_chk #(.AW(AW), .DW(DW)) i_chk (.mclk,
    .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .ext_addr, .area_select_n, .ext_ale, .ext_rd_n, .ext_we_n,
    .ext_data_out, .ext_data_oe, .ext_data_in, .ext_wait_n);

// >>> sim/ext_mem_model.sv
// Purpose: Device on area 5B: small memory with optional wait.
// Assumes: Address holds through the whole access.
// Notes: Released bus shows the inverse of the last value driven.
`timescale 1ns/10ps
module ext_mem_model (
    input wire logic mclk, // Clock
    input wire logic stall, // Ask for waits
    input wire logic [15:0] ext_addr, // Address
    input wire logic ext_rd_n, // Read strobe
    input wire logic ext_we_n, // Write strobe
    input wire logic [15:0] ext_data_out, // Write data
    output logic [15:0] ext_data_in, // Read data
    output logic ext_wait_n // Wait
);
    logic [15:0] mem_q [0:7];
    logic [15:0] last_q = 16'h0;
    logic [3:0] cnt_q = 4'h0;
    always @(posedge ext_we_n) mem_q[ext_addr[2:0]] <= ext_data_out;
    always @(posedge ext_rd_n) last_q <= mem_q[ext_addr[2:0]];
    always @(posedge mclk) cnt_q <= ext_rd_n ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
    assign ext_data_in = ext_rd_n ? ~last_q : mem_q[ext_addr[2:0]];
    // Wait held long enough to pass the three-flop filter
    assign ext_wait_n = !(stall && !ext_rd_n && cnt_q < 4'h8);
endmodule // ext_mem_model

// >>> sim/tb.sv
// Purpose: Register and external access tests for area wait control.
// Assumes: Device model on the pins, 10 MHz clock.
// Notes: Setup and strobe are counted in rising edges.
`timescale 1ns/10ps
module tb;
    import area_wait_pkg::*;
    logic mclk, resetn, avs_read, avs_write, stall;
    logic [2:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic avs_waitrequest, area_select_n, ext_ale, ext_rd_n, ext_we_n, ext_data_oe, ext_wait_n;
    logic [15:0] ext_addr, ext_data_out, ext_data_in;
    int err_count = 0, samples_checked = 0, cyc = 0, setup_n = 0, strobe_n = 0;
    int rtab[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
    area_bus_wait_control i_area_bus_wait_control (.mclk, .resetn, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .ext_addr, .area_select_n,
        .ext_ale, .ext_rd_n, .ext_we_n, .ext_data_out, .ext_data_oe, .ext_data_in, .ext_wait_n);
    ext_mem_model i_ext_mem_model (.mclk, .stall, .ext_addr, .ext_rd_n, .ext_we_n,
        .ext_data_out, .ext_data_in, .ext_wait_n);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (!area_select_n && strobe_n == 0 && ext_rd_n && ext_we_n) setup_n++;
        if (!ext_rd_n || !ext_we_n) strobe_n++;
        if (cyc == 6000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
            output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    // One external access; reads must return what the write loop stored
    task automatic run(input logic mpx, input logic [2:0] ww, input logic [1:0] sw,
            input logic [3:0] rw, input logic [2:0] cmd, input logic [15:0] a);
        logic [31:0] q;
        bus(1'b1, REG_WAIT_CTRL, {11'h0, mpx, 1'b0, ww, 3'h0, sw, rw, 7'h0}, q);
        bus(1'b1, REG_EXT_ADDR, {16'h0, a}, q);
        bus(1'b1, REG_EXT_DATA, {16'h0, (cmd == 3'h1) ? 16'h0 : 16'ha500 + a}, q);
        setup_n = 0;
        strobe_n = 0;
        bus(1'b1, REG_COMMAND, {29'h0, cmd}, q);
        do bus(1'b0, REG_COMMAND, 32'h0, q); while (q[0] !== 1'b0);
        bus(1'b0, REG_EXT_DATA, 32'h0, q);
        // A write leaves the read result alone, so look in the device instead
        if (cmd == 3'h2) begin
            q = {16'h0, i_ext_mem_model.mem_q[a[2:0]]};
        end
        chk(q, {16'h0, 16'ha500 + a});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        logic [31:0] q;
        resetn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 3'h0;
        avs_writedata = 32'h0;
        stall = 1'b0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        bus(1'b0, REG_WAIT_CTRL, 32'h0, q);
        chk(q, {21'h0, READ_WAIT_RESET, 7'h0});
        bus(1'b1, REG_WAIT_CTRL, 32'hffffffff, q);
        bus(1'b0, REG_WAIT_CTRL, 32'h0, q);
        chk(q, WAIT_CTRL_MASK);
        bus(1'b1, 3'h5, 32'hffffffff, q);
        bus(1'b0, 3'h5, 32'h0, q);
        chk(q, 32'h0);
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            run(1'b0, i[2:0], i[1:0], 4'h3, 3'h2, i[15:0]);
            chk(setup_n, i % 4);
            chk(strobe_n, (i == 0) ? 4 : i);
        end
        $display("write wait test done");
        for (int j = 0; j < 13; j++) begin
            run(1'b0, 3'h1, j[1:0], j[3:0], 3'h1, {13'h0, j[2:0]});
            chk(setup_n, j % 4);
            chk(strobe_n, rtab[j] + 1);
        end
        $display("read wait test done");
        bus(1'b1, REG_AREA_MODE, 32'h1, q);
        for (int k = 0; k < 2; k++) begin
            run(k[0], 3'h1, 2'h1, 4'h0, 3'h1, 16'h2);
            chk(setup_n, 2 + k);
        end
        bus(1'b1, REG_AREA_MODE, 32'h2, q);
        stall <= 1'b1;
        run(1'b1, 3'h1, 2'h1, 4'h4, 3'h1, 16'h3);
        chk(setup_n, 1);
        chk(strobe_n > 5, 1);
        $display("mux and wait pin test done");
        print_verdict();
    end
endmodule // tb
